// ### inc/gpx_cfg.svh
`ifndef GPX_CFG_SVH
`define GPX_CFG_SVH

// ************************************************************
// Register byte offsets on the APB window.
// ************************************************************
`define GPX_OFS_BPP_DATA   12'h070
`define GPX_OFS_BWP_DATA   12'h074
`define GPX_OFS_BPP_CTRL   12'h078
`define GPX_OFS_MODE       12'h07C
`define GPX_OFS_HDR_MASK   12'h0E0
`define GPX_OFS_HDR_DATA   12'h0E4
`define GPX_OFS_HDR_DIRFLG 12'h0E8

// ************************************************************
// Field positions.
// ************************************************************
`define GPX_MODE_IRQ_FLAG  6
`define GPX_MODE_STB_FLAG  7
`define GPX_HDR_FLAG_LSB   2

// ************************************************************
// Reset values.
// ************************************************************
`define GPX_RST_BYTE       8'h00
`define GPX_RST_MODE       6'h00
`define GPX_RST_HMASK      6'h00
`define GPX_RST_PAIR       2'h0
`define GPX_RST_OE_N       8'hFF

// ************************************************************
// Timing: fixed sample clock derived from the bus clock.
// ************************************************************
`define GPX_PCLK_MHZ       10
`define GPX_FIXED_SMP_MHZ  8

`endif

// ### inc/gpx_pkg.sv
package gpx_pkg;

   // Selects what the shared control offset reaches.
   typedef enum logic [1:0] {
      GPX_SEL_CLR  = 2'h0,
      GPX_SEL_DIR  = 2'h1,
      GPX_SEL_MASK = 2'h2,
      GPX_SEL_CMP  = 2'h3
   } gpx_sel_t;

   // Programmable part of the digital mode register, bit 5 down to bit 0.
   typedef struct packed {
      logic     smp_prog;
      logic     irq_en;
      logic     match;
      logic     byte_out;
      gpx_sel_t sel;
   } gpx_mode_t;

   // Control registers of the bit programmable port.
   typedef struct packed {
      logic [7:0] dir;
      logic [7:0] mask;
      logic [7:0] cmp;
   } gpx_bpp_ctl_t;

endpackage : gpx_pkg

// ### rtl/gpx_sync.sv
`timescale 1ns/1ns
`default_nettype none

// ************************************************************
// Two stage synchroniser for a group of levels.
// ************************************************************
module gpx_sync #(
   parameter int W = 8
) (
   input  wire logic         clk,     // Sampling clock.
   input  wire logic         rst_n,   // Asynchronous reset, active low.
   input  wire logic [W-1:0] d,       // Raw pin levels.
   output logic      [W-1:0] q        // Synchronised levels.
);

   logic [W-1:0] meta_ff;

   // First stage feeds only the second stage.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_ff <= '0;
         q       <= '0;
      end else begin
         meta_ff <= d;
         q       <= meta_ff;
      end
   end

endmodule : gpx_sync

`default_nettype wire

// ### rtl/gpx_top.sv
// The APB slave port was left to the implementer.
`include "gpx_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module gpx_top (
   input  wire logic        pclk,        // Bus clock, 10 MHz.
   input  wire logic        presetn,     // Asynchronous reset, active low.
   input  wire logic        psel,        // APB select.
   input  wire logic        penable,     // APB enable.
   input  wire logic        pwrite,      // APB direction, high for write.
   input  wire logic [11:0] paddr,       // APB byte address.
   input  wire logic [31:0] pwdata,      // APB write data.
   output logic      [31:0] prdata,      // APB read data.
   output logic             pready,      // APB ready.
   output logic             pslverr,     // APB error on unmapped offset.
   input  wire logic [7:0]  bpp_in,      // Bit programmable port pin levels.
   output logic      [7:0]  bpp_out,     // Bit programmable port drive values.
   output logic      [7:0]  bpp_oe_n,    // Low while the bit is driven.
   input  wire logic [7:0]  bwp_in,      // Byte wide port pin levels.
   output logic      [7:0]  bwp_out,     // Byte wide port drive values.
   output logic             bwp_oe_n,    // Low while the byte is driven.
   input  wire logic [1:0]  hdr_in,      // Header line pin levels.
   output logic      [1:0]  hdr_out,     // Header line drive values.
   output logic      [1:0]  hdr_oe_n,    // Low while a header line is driven.
   input  wire logic        strobe_in,   // External strobe input.
   input  wire logic        prog_tick,   // Programmable sample clock pulse.
   input  wire logic        other_irq,   // Other board interrupt sources.
   output logic             dig_irq,     // Digital interrupt request level.
   output logic             local_irq    // Combined local bus interrupt.
);

   // ************************************************************
   // State.
   // ************************************************************
   gpx_pkg::gpx_mode_t    mode_ff;
   gpx_pkg::gpx_bpp_ctl_t ctl_ff;
   logic [7:0]  out0_ff;
   logic [7:0]  out1_ff;
   logic        irq_flag_ff;
   logic        stb_flag_ff;
   logic [5:0]  hmask_ff;
   logic [1:0]  hdata_ff;
   logic [1:0]  hdir_ff;
   logic [3:0]  hflags_ff;
   logic [7:0]  smp0_ff;
   logic [7:0]  prev0_ff;
   logic        match_prev_ff;
   logic [1:0]  hprev_ff;
   logic        stb_prev_ff;
   logic [3:0]  acc_ff;
   logic        fix_tick_ff;
   logic [31:0] prdata_ff;
   logic        pready_ff;
   logic        pslverr_ff;
   logic [7:0]  bpp_oe_n_ff;
   logic        bwp_oe_n_ff;
   logic [1:0]  hdr_oe_n_ff;
   logic [1:0]  hdr_out_ff;
   logic        local_irq_ff;

   logic [7:0]  bpp_s;
   logic [7:0]  bwp_s;
   logic [1:0]  hdr_s;
   logic        stb_s;

   // ************************************************************
   // Input synchronisers.
   // ************************************************************
   // Pins are brought through two flops before any detector looks at them.
   gpx_sync #(.W(19)) u_sync (
      .clk   (pclk),
      .rst_n (presetn),
      .d     ({strobe_in, hdr_in, bwp_in, bpp_in}),
      .q     ({stb_s, hdr_s, bwp_s, bpp_s})
   );

   // ************************************************************
   // Bus decode.
   // ************************************************************
   logic acc;
   logic wr;
   logic rd;
   logic [31:0] nxt_prdata;
   logic        nxt_err;
   logic [7:0]  rd_bpp;
   logic [7:0]  rd_bwp;

   // A transfer takes effect at the edge where pready is seen high.
   assign acc = psel & penable & pready_ff;
   assign wr  = acc & pwrite;
   assign rd  = acc & ~pwrite;

   // Inputs show pin levels, outputs show the last driven value.
   assign rd_bpp = (ctl_ff.dir & out0_ff) | (~ctl_ff.dir & bpp_s);
   assign rd_bwp = mode_ff.byte_out ? out1_ff : bwp_s;

   // Read data is prepared from the offset in the first access cycle.
   always_comb begin
      nxt_prdata = 32'h0000_0000;
      nxt_err    = 1'b0;
      unique case (paddr)
         `GPX_OFS_BPP_DATA: nxt_prdata[7:0] = rd_bpp;
         `GPX_OFS_BWP_DATA: nxt_prdata[7:0] = rd_bwp;
         `GPX_OFS_BPP_CTRL: begin
            unique case (mode_ff.sel)
               gpx_pkg::GPX_SEL_CLR:  nxt_prdata[7:0] = 8'h00;
               gpx_pkg::GPX_SEL_DIR:  nxt_prdata[7:0] = ctl_ff.dir;
               gpx_pkg::GPX_SEL_MASK: nxt_prdata[7:0] = ctl_ff.mask;
               gpx_pkg::GPX_SEL_CMP:  nxt_prdata[7:0] = ctl_ff.cmp;
            endcase
         end
         `GPX_OFS_MODE:       nxt_prdata[7:0] = {stb_flag_ff, irq_flag_ff, mode_ff};
         `GPX_OFS_HDR_MASK:   nxt_prdata[5:0] = hmask_ff;
         `GPX_OFS_HDR_DATA:   nxt_prdata[1:0] = hdr_s;
         `GPX_OFS_HDR_DIRFLG: nxt_prdata[5:2] = hflags_ff;
         default:             nxt_err = 1'b1;
      endcase
   end

   // One wait state: pready rises in the second access cycle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_ff  <= 1'b0;
         prdata_ff  <= 32'h0000_0000;
         pslverr_ff <= 1'b0;
      end else begin
         pready_ff <= psel & penable & ~pready_ff;
         if (psel & penable & ~pready_ff) begin
            prdata_ff  <= pwrite ? 32'h0000_0000 : nxt_prdata;
            pslverr_ff <= nxt_err;
         end else begin
            pslverr_ff <= 1'b0;
         end
      end
   end

   // ************************************************************
   // Control register writes.
   // ************************************************************
   logic wr_ctl;
   logic chip_clr;
   logic flag_rd_clr;
   logic [7:0] wr_en0;

   assign wr_ctl      = wr & (paddr == `GPX_OFS_BPP_CTRL);
   assign chip_clr    = wr_ctl & (mode_ff.sel == gpx_pkg::GPX_SEL_CLR);
   assign flag_rd_clr = rd & (paddr == `GPX_OFS_BPP_CTRL) &
                        (mode_ff.sel == gpx_pkg::GPX_SEL_CLR);
   // Masked bits freeze only while pattern interrupts are off.
   assign wr_en0 = ctl_ff.dir & ~(ctl_ff.mask & {8{~mode_ff.irq_en}});

   logic evt_set;
   logic [7:0] chg0;

   // Mode register, with the port one direction cleared by a chip clear.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_ff <= `GPX_RST_MODE;
      end else if (wr & (paddr == `GPX_OFS_MODE)) begin
         mode_ff <= pwdata[5:0];
      end else if (chip_clr) begin
         mode_ff.byte_out <= 1'b0;
      end
   end

   // Direction, mask and compare behind the shared offset.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl_ff <= '0;
      end else if (chip_clr) begin
         ctl_ff <= '0;
      end else begin
         if (wr_ctl & (mode_ff.sel == gpx_pkg::GPX_SEL_DIR))
            ctl_ff.dir <= pwdata[7:0];
         if (wr_ctl & (mode_ff.sel == gpx_pkg::GPX_SEL_MASK))
            ctl_ff.mask <= pwdata[7:0];
         if (evt_set & ~mode_ff.match)
            ctl_ff.cmp <= smp0_ff;
         else if (wr_ctl & (mode_ff.sel == gpx_pkg::GPX_SEL_CMP))
            ctl_ff.cmp <= pwdata[7:0];
      end
   end

   // Output holding registers of both ports.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out0_ff <= `GPX_RST_BYTE;
         out1_ff <= `GPX_RST_BYTE;
      end else if (chip_clr) begin
         out0_ff <= `GPX_RST_BYTE;
         out1_ff <= `GPX_RST_BYTE;
      end else begin
         if (wr & (paddr == `GPX_OFS_BPP_DATA))
            out0_ff <= (out0_ff & ~wr_en0) | (pwdata[7:0] & wr_en0);
         if (wr & (paddr == `GPX_OFS_BWP_DATA) & mode_ff.byte_out)
            out1_ff <= pwdata[7:0];
      end
   end

   // ************************************************************
   // Sample clock and pattern interrupt.
   // ************************************************************
   logic [4:0] acc_sum;

   // The sum is one bit wider so that it cannot wrap before the compare.
   assign acc_sum = {1'b0, acc_ff} + 5'(`GPX_FIXED_SMP_MHZ);

   // An 8 of 10 cycle accumulator stands in for the fixed sample clock.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc_ff      <= 4'h0;
         fix_tick_ff <= 1'b0;
      end else if (acc_sum >= 5'(`GPX_PCLK_MHZ)) begin
         acc_ff      <= 4'(acc_sum - 5'(`GPX_PCLK_MHZ));
         fix_tick_ff <= 1'b1;
      end else begin
         acc_ff      <= acc_sum[3:0];
         fix_tick_ff <= 1'b0;
      end
   end

   logic smp_en;
   logic match_now;

   assign smp_en    = mode_ff.smp_prog ? prog_tick : fix_tick_ff;
   assign chg0      = (smp0_ff ^ prev0_ff) & ~ctl_ff.mask;
   assign match_now = ((smp0_ff ^ ctl_ff.cmp) & ~ctl_ff.mask) == 8'h00;
   // A match raises the flag once as it begins, a change on every change.
   assign evt_set   = mode_ff.irq_en &
                      (mode_ff.match ? (match_now & ~match_prev_ff) : (|chg0));

   // Port zero is sampled on the selected clock.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         smp0_ff       <= `GPX_RST_BYTE;
         prev0_ff      <= `GPX_RST_BYTE;
         match_prev_ff <= 1'b0;
      end else begin
         if (smp_en)
            smp0_ff <= bpp_s;
         prev0_ff      <= smp0_ff;
         match_prev_ff <= match_now;
      end
   end

   // Sticky flags; a new event wins over a clearing read.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_flag_ff <= 1'b0;
         stb_flag_ff <= 1'b0;
         stb_prev_ff <= 1'b0;
      end else begin
         stb_prev_ff <= stb_s;
         if (evt_set)
            irq_flag_ff <= 1'b1;
         else if (flag_rd_clr)
            irq_flag_ff <= 1'b0;
         if (stb_s & ~stb_prev_ff)
            stb_flag_ff <= 1'b1;
         else if (flag_rd_clr)
            stb_flag_ff <= 1'b0;
      end
   end

   // ************************************************************
   // Header lines.
   // ************************************************************
   logic [1:0] hrise;
   logic [1:0] hfall;
   logic       hflag_rd;

   assign hrise    = hdr_s & ~hprev_ff & ~hdir_ff & hmask_ff[3:2];
   assign hfall    = ~hdr_s & hprev_ff & ~hdir_ff & hmask_ff[5:4];
   assign hflag_rd = rd & (paddr == `GPX_OFS_HDR_DIRFLG);

   // Header mask, data and direction registers.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hmask_ff <= `GPX_RST_HMASK;
         hdata_ff <= `GPX_RST_PAIR;
         hdir_ff  <= `GPX_RST_PAIR;
      end else begin
         if (wr & (paddr == `GPX_OFS_HDR_MASK))
            hmask_ff <= pwdata[5:0];
         if (wr & (paddr == `GPX_OFS_HDR_DATA))
            hdata_ff <= pwdata[1:0];
         if (wr & (paddr == `GPX_OFS_HDR_DIRFLG))
            hdir_ff <= pwdata[1:0];
      end
   end

   // Edge flags, cleared by a read unless a new edge arrives.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hflags_ff <= 4'h0;
         hprev_ff  <= `GPX_RST_PAIR;
      end else begin
         hprev_ff  <= hdr_s;
         hflags_ff <= (hflag_rd ? 4'h0 : hflags_ff) | {hfall, hrise};
      end
   end

   // ************************************************************
   // Registered pin and interrupt outputs.
   // ************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bpp_oe_n_ff  <= `GPX_RST_OE_N;
         bwp_oe_n_ff  <= 1'b1;
         hdr_oe_n_ff  <= 2'h3;
         hdr_out_ff   <= `GPX_RST_PAIR;
         local_irq_ff <= 1'b0;
      end else begin
         bpp_oe_n_ff  <= ~ctl_ff.dir;
         bwp_oe_n_ff  <= ~mode_ff.byte_out;
         hdr_oe_n_ff  <= ~(hdir_ff & hmask_ff[1:0]);
         hdr_out_ff   <= hdata_ff;
         local_irq_ff <= (|hflags_ff) | irq_flag_ff | other_irq;
      end
   end

   assign prdata    = prdata_ff;
   assign pready    = pready_ff;
   assign pslverr   = pslverr_ff;
   assign bpp_out   = out0_ff;
   assign bpp_oe_n  = bpp_oe_n_ff;
   assign bwp_out   = out1_ff;
   assign bwp_oe_n  = bwp_oe_n_ff;
   assign hdr_out   = hdr_out_ff;
   assign hdr_oe_n  = hdr_oe_n_ff;
   assign dig_irq   = irq_flag_ff;
   assign local_irq = local_irq_ff;

   // ************************************************************
   // Assertions.
   // ************************************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence clr_write_s;
      chip_clr;
   endsequence
   sequence lines_input_s;
      (ctl_ff.dir == 8'h00) && (out0_ff == 8'h00) && !mode_ff.byte_out ##1 (bpp_oe_n == 8'hFF) && bwp_oe_n;
   endsequence

   chip_clear_a: assert property (clr_write_s |=> lines_input_s)
      else $error("chip clear left a line driven");
   input_wr_a: assert property (wr && paddr == `GPX_OFS_BPP_DATA && !chip_clr |=>
         ((out0_ff & ~ctl_ff.dir) == ($past(out0_ff) & ~$past(ctl_ff.dir))))
      else $error("write changed an input bit");
   mask_hold_a: assert property (wr && paddr == `GPX_OFS_BPP_DATA && !mode_ff.irq_en
         |=> ((out0_ff & ctl_ff.mask) == ($past(out0_ff) & ctl_ff.mask)))
      else $error("masked output bit changed");
   byte_wr_a: assert property (wr && paddr == `GPX_OFS_BWP_DATA && mode_ff.byte_out
         |=> out1_ff == $past(pwdata[7:0]) ##1 bwp_out == $past(pwdata[7:0], 2))
      else $error("byte port write not driven");
   match_irq_a: assert property (mode_ff.irq_en && mode_ff.match && match_now && !match_prev_ff
         |=> irq_flag_ff [*2])
      else $error("match did not raise interrupt");
   event_latch_a: assert property (mode_ff.irq_en && !mode_ff.match && (|chg0)
         |=> irq_flag_ff && ctl_ff.cmp == $past(smp0_ff))
      else $error("event value not latched");
   irq_gate_a: assert property (!mode_ff.irq_en && !irq_flag_ff |=> !irq_flag_ff)
      else $error("disabled interrupt was raised");
   hdr_edge_a: assert property (|hrise |=> (hflags_ff[1:0] & $past(hrise)) == $past(hrise)
         ##1 local_irq)
      else $error("header edge not flagged");
   hdr_clear_a: assert property (hflag_rd && hrise == 2'h0 && hfall == 2'h0 |=> hflags_ff == 4'h0)
      else $error("header flags not cleared by read");

endmodule : gpx_top

`default_nettype wire

// ### verification/gpx_pins.sv
`timescale 1ns/1ns
`default_nettype none

// ************************************************************
// Far side devices on the port and header pins.
// ************************************************************
module gpx_pins (
   input  wire logic [17:0] drv,   // Values the block drives.
   input  wire logic [17:0] oe_n,  // Low while the block drives.
   input  wire logic [17:0] ext,   // Levels of the far devices.
   output logic      [17:0] pin    // Resolved line levels.
);
   // A driven line shows the block's value, a released one the device level.
   always_comb begin
      for (int i = 0; i < 18; i++) begin
         pin[i] = oe_n[i] ? ext[i] : drv[i];
      end
   end
endmodule : gpx_pins

`default_nettype wire

// ### verification/gpx_top_tb.sv
`timescale 1ns/1ns
`default_nettype none

`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin fails++; \
   $display("wrong value %s exp %h got %h", n, e, s); end end

// ************************************************************
// Self-checking bench of the digital ports.
// ************************************************************
module gpx_top_tb;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
   logic        strobe_in = 0, prog_tick = 0, other_irq = 0, pready, pslverr, bwp_oe_n, dig_irq, local_irq;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'h3FCDD0D6;
   logic [7:0]  bpp_out, bpp_oe_n, bwp_out, bpp_in, bwp_in, dv, mv, w, w0;
   logic [1:0]  hdr_out, hdr_oe_n, hdr_in;
   logic [17:0] ext = 18'h0;
   int          fails = 0, checks_done = 0;

   gpx_top i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .bpp_in, .bpp_out, .bpp_oe_n, .bwp_in, .bwp_out, .bwp_oe_n, .hdr_in, .hdr_out, .hdr_oe_n,
      .strobe_in, .prog_tick, .other_irq, .dig_irq, .local_irq);
   gpx_pins i_pins (.drv({hdr_out, bwp_out, bpp_out}), .oe_n({hdr_oe_n, {8{bwp_oe_n}}, bpp_oe_n}),
      .ext(ext), .pin({hdr_in, bwp_in, bpp_in}));

   // Free running bus clock.
   initial begin
      forever #50 pclk = ~pclk;
   end

   // Next byte of the xorshift sequence.
   function automatic logic [7:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction : rnd

   // Output bits where s is set, input bits elsewhere.
   function automatic logic [7:0] mix(logic [7:0] o, logic [7:0] i, logic [7:0] s);
      return (o & s) | (i & ~s);
   endfunction : mix

   // Prints the counts and the verdict, then stops.
   task automatic close_out();
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : close_out

   task automatic wt(int n);
      repeat (n) @(posedge pclk);
   endtask : wt

   // One APB transfer; read data and error are taken at the ready edge.
   task automatic bus(logic wr, logic [11:0] a, logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         fails++;
         close_out();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : bus

   // Main sequence of scenarios.
   initial begin
      wt(5);
      presetn <= 1'b1;
      `CHK("oe0", 8'hFF, bpp_oe_n)
      bus(0, 12'h07C, 0);
      `CHK("mode", 32'h0, rd)
      for (int k = 0; k < 4; k++) begin
         dv = rnd();
         w = rnd();
         ext[7:0] <= rnd();
         bus(1, 12'h07C, 32'h01);
         bus(1, 12'h078, {24'h0, dv});
         bus(1, 12'h070, {24'h0, w});
         wt(4);
         bus(0, 12'h070, 0);
         `CHK("p0", {24'h0, mix(w, ext[7:0], dv)}, rd)
         `CHK("oe0", ~dv, bpp_oe_n)
         bus(0, 12'h078, 0);
         `CHK("dir", {24'h0, dv}, rd)
      end
      w0 = rnd();
      mv = rnd();
      w = rnd();
      bus(1, 12'h078, 32'hFF);
      bus(1, 12'h070, {24'h0, w0});
      bus(1, 12'h07C, 32'h02);
      bus(1, 12'h078, {24'h0, mv});
      bus(1, 12'h070, {24'h0, w});
      wt(2);
      `CHK("hold", mix(w0, w, mv), bpp_out)
      ext[15:8] <= rnd();
      bus(1, 12'h074, 32'hA5);
      wt(4);
      bus(0, 12'h074, 0);
      `CHK("p1in", {24'h0, ext[15:8]}, rd)
      bus(1, 12'h07C, 32'h04);
      bus(1, 12'h074, 32'h5A);
      wt(4);
      bus(0, 12'h074, 0);
      `CHK("p1out", 32'h5A, rd)
      `CHK("p1drv", 9'h05A, {bwp_oe_n, bwp_out})
      bus(1, 12'h078, 0);
      wt(2);
      `CHK("clr", {1'b1, 8'hFF}, {bwp_oe_n, bpp_oe_n})
      `CHK("clrout", 16'h0000, {bwp_out, bpp_out})
      bus(0, 12'h100, 0);
      `CHK("slverr", 1'b1, err)
      bus(1, 12'h0E0, 32'h04);
      bus(1, 12'h0E8, 0);
      ext[17:16] <= 2'b01;
      wt(6);
      `CHK("lirq", 1'b1, local_irq)
      bus(0, 12'h0E8, 0);
      `CHK("hflg", 32'h4, rd)
      bus(0, 12'h0E8, 0);
      `CHK("hflg", 32'h0, rd)
      `CHK("lirq0", 1'b0, local_irq)
      other_irq <= 1'b1;
      wt(2);
      `CHK("oirq", 1'b1, local_irq)
      other_irq <= 1'b0;
      bus(1, 12'h0E0, 32'h03);
      bus(1, 12'h0E8, 32'h03);
      bus(1, 12'h0E4, 32'h02);
      wt(4);
      bus(0, 12'h0E4, 0);
      `CHK("hdr", 32'h2, rd)
      `CHK("hdrpin", 4'h2, {hdr_oe_n, hdr_out})
      strobe_in <= 1'b1;
      bus(1, 12'h07C, 32'h10);
      w = ~ext[7:0];
      ext[7:0] <= w;
      wt(12);
      `CHK("evirq", 1'b1, dig_irq)
      bus(0, 12'h07C, 0);
      `CHK("flag", 1'b1, rd[6])
      `CHK("stb", 1'b1, rd[7])
      bus(1, 12'h07C, 32'h13);
      bus(0, 12'h078, 0);
      `CHK("latch", {24'h0, w}, rd)
      bus(1, 12'h07C, 32'h18);
      bus(0, 12'h078, 0);
      wt(2);
      `CHK("rdclr", 1'b0, dig_irq)
      bus(0, 12'h07C, 0);
      `CHK("modeclr", 8'h18, rd[7:0])
      dv = rnd();
      bus(1, 12'h07C, 32'h1B);
      bus(1, 12'h078, {24'h0, dv});
      ext[7:0] <= dv;
      wt(12);
      `CHK("match", 1'b1, dig_irq)
      bus(1, 12'h07C, 32'h30);
      bus(0, 12'h078, 0);
      ext[7:0] <= ~dv;
      wt(12);
      `CHK("progidle", 1'b0, dig_irq)
      prog_tick <= 1'b1;
      wt(1);
      prog_tick <= 1'b0;
      wt(4);
      `CHK("progirq", 1'b1, dig_irq)
      close_out();
   end
endmodule : gpx_top_tb

`default_nettype wire
